// >>> include/flash_prog_pkg.sv
package flash_prog_pkg;

	// ==========================================
	// Register map (byte addresses, one word each)
	localparam logic [7:0] CHIP_CONTROL_OFS  = 8'h00;
	localparam logic [7:0] FLASH_ADDR_HI_OFS = 8'h04;
	localparam logic [7:0] FLASH_ADDR_LO_OFS = 8'h08;
	localparam logic [7:0] FLASH_DATA_OFS    = 8'h0c;
	localparam logic [7:0] FLASH_CMD_OFS     = 8'h10;
	localparam logic [7:0] FLASH_TRIG_OFS    = 8'h14;
	localparam logic [7:0] UNLOCK_OFS        = 8'h18;
	localparam logic [7:0] STATUS_OFS        = 8'h1c;

	// ==========================================
	// Field positions and reset values
	localparam int          PROG_ENABLE_BIT = 0;
	localparam int          FLASH_GO_BIT    = 0;
	localparam int          BUSY_BIT        = 0;
	localparam int          REFUSED_BIT     = 1;
	localparam logic [7:0]  BYTE_RESET      = 8'h00;

	// ==========================================
	// Unlock keys written in order to the unlock register
	localparam logic [7:0] UNLOCK_KEY1 = 8'haa;
	localparam logic [7:0] UNLOCK_KEY2 = 8'h55;

	// ==========================================
	// Command codes (arbitrary neutral encodings)
	localparam logic [7:0] CMD_ERASE   = 8'h22;
	localparam logic [7:0] CMD_PROGRAM = 8'h21;
	localparam logic [7:0] CMD_VERIFY  = 8'h00;

	// ==========================================
	// Flash timing, in nanoseconds at a 40 ns clock
	localparam int CLK_NS       = 40;
	localparam int SETUP_NS     = 200;
	localparam int PUMP_NS      = 1000;
	localparam int PROG_NS      = 20000;
	localparam int ERASE_NS     = 5000000;
	localparam int VERIFY_NS    = 400;
	localparam int SETUP_CYC    = (SETUP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PUMP_CYC     = (PUMP_NS + CLK_NS - 1) / CLK_NS;
	localparam int PROG_CYC     = (PROG_NS + CLK_NS - 1) / CLK_NS;
	localparam int ERASE_CYC    = (ERASE_NS + CLK_NS - 1) / CLK_NS;
	localparam int VERIFY_CYC   = (VERIFY_NS + CLK_NS - 1) / CLK_NS;

	// ==========================================
	// Sequencer states
	typedef enum logic [2:0] {
		ST_IDLE,
		ST_SETUP,
		ST_PUMP,
		ST_ACTION,
		ST_RELEASE
	} seq_state_t;

	// Signals towards the flash array
	typedef struct packed {
		logic [15:0] addr;
		logic [7:0]  wdata;
		logic        pump_on;
		logic        erase;
		logic        prog;
		logic        read;
	} flash_ctrl_t;

endpackage : flash_prog_pkg

// >>> hw/in_system_flash_programmer.sv
`timescale 1ns/10ps
`default_nettype none

// How it works
// - Operations need prog_enable, written under unlock
// - Sixteen-bit address from high and low registers
// - Loaded command acts on loaded data byte
// - Setting go bit starts the operation
// - Go bit writes need the unlock sequence
// - Program counter held during operation
// - Automation drives pump and flash timing
// - Program counter released on completion
// - Go bit cleared by hardware on completion
// - Erase, program, verify; repeatable per load
module in_system_flash_programmer
	import flash_prog_pkg::*;
#(
	parameter int ERASE_CYCLES = ERASE_CYC
) (
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic      [31:0] wb_dat_o,
	output logic             wb_ack_o,
	output logic             wb_err_o,
	output logic             cpu_hold_o,
	output var flash_ctrl_t  flash_ctrl_o,
	input  wire logic [7:0]  flash_rdata_i
);

	// ==========================================
	// Bus decode
	logic        req;
	logic        wr;
	logic        mapped;
	logic [7:0]  wbyte;

	assign req    = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
	assign wr     = req & wb_we_i & wb_sel_i[0];
	assign wbyte  = wb_dat_i[7:0];

	// Address decode used for the answer choice
	function automatic logic is_mapped(input logic [7:0] a);
		case (a)
			CHIP_CONTROL_OFS, FLASH_ADDR_HI_OFS, FLASH_ADDR_LO_OFS, FLASH_DATA_OFS,
			FLASH_CMD_OFS, FLASH_TRIG_OFS, UNLOCK_OFS, STATUS_OFS: is_mapped = 1'b1;
			default: is_mapped = 1'b0;
		endcase
	endfunction

	assign mapped = is_mapped(wb_adr_i);

	// ==========================================
	// Register and sequencer state
	logic        prog_enable;
	logic [7:0]  flash_addr_high;
	logic [7:0]  flash_addr_low;
	logic [7:0]  flash_data_reg;
	logic [7:0]  flash_command_reg;
	logic        flash_go;
	logic [1:0]  unlock_stage;
	logic        refused;
	logic [7:0]  read_back;
	logic [31:0] dat_q;
	logic        ack_q;
	logic        err_q;
	seq_state_t  state;
	logic [31:0] count;

	logic        next_prog_enable;
	logic [7:0]  next_flash_addr_high;
	logic [7:0]  next_flash_addr_low;
	logic [7:0]  next_flash_data_reg;
	logic [7:0]  next_flash_command_reg;
	logic        next_flash_go;
	logic [1:0]  next_unlock_stage;
	logic        next_refused;
	logic [7:0]  next_read_back;
	logic [31:0] next_dat_q;
	logic        next_ack_q;
	logic        next_err_q;
	seq_state_t  next_state;
	logic [31:0] next_count;
	logic        protected_ok;
	logic        start;
	logic        done;
	logic        cmd_ok;
	logic [31:0] action_len;

	// Unlock window is open only after both keys in sequence
	assign protected_ok = (unlock_stage == 2'd2);

	// Command validity and action length
	always_comb begin
		cmd_ok     = 1'b1;
		action_len = 32'(VERIFY_CYC);
		case (flash_command_reg)
			CMD_ERASE:   action_len = 32'(ERASE_CYCLES);
			CMD_PROGRAM: action_len = 32'(PROG_CYC);
			CMD_VERIFY:  action_len = 32'(VERIFY_CYC);
			default:     cmd_ok = 1'b0;
		endcase
	end

	// ==========================================
	// Register next values
	always_comb begin
		next_prog_enable       = prog_enable;
		next_flash_addr_high   = flash_addr_high;
		next_flash_addr_low    = flash_addr_low;
		next_flash_data_reg    = flash_data_reg;
		next_flash_command_reg = flash_command_reg;
		next_flash_go          = flash_go;
		next_unlock_stage      = unlock_stage;
		next_refused           = refused;
		next_read_back         = read_back;
		start                  = 1'b0;
		next_dat_q             = 32'h0000_0000;
		next_ack_q             = req & mapped;
		next_err_q             = req & ~mapped;

		if (wr && protected_ok) begin
			next_unlock_stage = 2'd0;
		end
		if (wr && wb_adr_i == UNLOCK_OFS) begin
			if (wbyte == UNLOCK_KEY1) begin
				next_unlock_stage = 2'd1;
			end else if (wbyte == UNLOCK_KEY2 && unlock_stage == 2'd1) begin
				next_unlock_stage = 2'd2;
			end else begin
				next_unlock_stage = 2'd0;
			end
		end else if (wr && unlock_stage == 2'd1) begin
			next_unlock_stage = 2'd0;
		end

		if (wr && state == ST_IDLE) begin
			case (wb_adr_i)
				CHIP_CONTROL_OFS: begin
					if (protected_ok) begin
						next_prog_enable = wbyte[PROG_ENABLE_BIT];
					end
				end
				FLASH_ADDR_HI_OFS: next_flash_addr_high = wbyte;
				FLASH_ADDR_LO_OFS: next_flash_addr_low = wbyte;
				FLASH_DATA_OFS: next_flash_data_reg = wbyte;
				FLASH_CMD_OFS: next_flash_command_reg = wbyte;
				FLASH_TRIG_OFS: begin
					if (wbyte[FLASH_GO_BIT]) begin
						if (protected_ok && prog_enable && cmd_ok) begin
							next_flash_go = 1'b1;
							start         = 1'b1;
							next_refused  = 1'b0;
						end else begin
							next_refused = 1'b1;
						end
					end
				end
				default: ;
			endcase
		end

		// Verify result captured from array at end of read
		if (done && flash_command_reg == CMD_VERIFY) begin
			next_read_back = flash_rdata_i;
		end
		if (done) begin
			next_flash_go = 1'b0;
		end

		// Read data mux
		case (wb_adr_i)
			CHIP_CONTROL_OFS:  next_dat_q[PROG_ENABLE_BIT] = prog_enable;
			FLASH_ADDR_HI_OFS: next_dat_q[7:0] = flash_addr_high;
			FLASH_ADDR_LO_OFS: next_dat_q[7:0] = flash_addr_low;
			FLASH_DATA_OFS:    next_dat_q[7:0] = (flash_command_reg == CMD_VERIFY) ?
			                                     read_back : flash_data_reg;
			FLASH_CMD_OFS:     next_dat_q[7:0] = flash_command_reg;
			FLASH_TRIG_OFS:    next_dat_q[FLASH_GO_BIT] = flash_go;
			STATUS_OFS: begin
				next_dat_q[BUSY_BIT]    = (state != ST_IDLE);
				next_dat_q[REFUSED_BIT] = refused;
			end
			default: ;
		endcase
	end

	// ==========================================
	// Sequencer next state
	always_comb begin
		next_state = state;
		next_count = count;
		done       = 1'b0;
		case (state)
			ST_IDLE: begin
				if (start) begin
					next_state = ST_SETUP;
					next_count = 32'(SETUP_CYC);
				end
			end
			ST_SETUP: begin
				if (count <= 32'd1) begin
					next_state = ST_PUMP;
					next_count = 32'(PUMP_CYC);
				end else begin
					next_count = count - 32'd1;
				end
			end
			ST_PUMP: begin
				if (count <= 32'd1) begin
					next_state = ST_ACTION;
					next_count = action_len;
				end else begin
					next_count = count - 32'd1;
				end
			end
			ST_ACTION: begin
				if (count <= 32'd1) begin
					next_state = ST_RELEASE;
					next_count = 32'd0;
					done       = 1'b1;
				end else begin
					next_count = count - 32'd1;
				end
			end
			ST_RELEASE: next_state = ST_IDLE;
			default: begin
				next_state = ST_IDLE;
				next_count = 32'd0;
			end
		endcase
	end

	// ==========================================
	// State registers
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			prog_enable       <= 1'b0;
			flash_addr_high   <= BYTE_RESET;
			flash_addr_low    <= BYTE_RESET;
			flash_data_reg    <= BYTE_RESET;
			flash_command_reg <= BYTE_RESET;
			flash_go          <= 1'b0;
			unlock_stage      <= 2'd0;
			refused           <= 1'b0;
			read_back         <= BYTE_RESET;
			dat_q             <= 32'h0000_0000;
			ack_q             <= 1'b0;
			err_q             <= 1'b0;
			state             <= ST_IDLE;
			count             <= 32'd0;
		end else begin
			prog_enable       <= next_prog_enable;
			flash_addr_high   <= next_flash_addr_high;
			flash_addr_low    <= next_flash_addr_low;
			flash_data_reg    <= next_flash_data_reg;
			flash_command_reg <= next_flash_command_reg;
			flash_go          <= next_flash_go;
			unlock_stage      <= next_unlock_stage;
			refused           <= next_refused;
			read_back         <= next_read_back;
			dat_q             <= next_dat_q;
			ack_q             <= next_ack_q;
			err_q             <= next_err_q;
			state             <= next_state;
			count             <= next_count;
		end
	end

	// ==========================================
	// Outputs
	assign wb_dat_o = dat_q;
	assign wb_ack_o = ack_q;
	assign wb_err_o = err_q;

	assign cpu_hold_o = flash_go;

	always_comb begin
		flash_ctrl_o.addr    = {flash_addr_high, flash_addr_low};
		flash_ctrl_o.wdata   = flash_data_reg;
		flash_ctrl_o.pump_on = (state == ST_PUMP) ||
		                       ((state == ST_ACTION) && flash_command_reg != CMD_VERIFY);
		flash_ctrl_o.erase   = (state == ST_ACTION) && (flash_command_reg == CMD_ERASE);
		flash_ctrl_o.prog    = (state == ST_ACTION) && (flash_command_reg == CMD_PROGRAM);
		flash_ctrl_o.read    = (state == ST_ACTION) && (flash_command_reg == CMD_VERIFY);
	end

endmodule // in_system_flash_programmer

`default_nettype wire

// >>> dv/flash_array_model.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Flash array seen from the sequencer
module flash_array_model
	import flash_prog_pkg::*;
(
	input  wire logic        clk_i,
	input  wire flash_ctrl_t ctrl_i,
	output logic      [7:0]  rdata_o
);
	logic [7:0] cells [0:65535];
	logic [7:0] last;

	// full address, loaded byte, each operation
	always @(posedge clk_i) begin
		if (ctrl_i.erase)
			cells[ctrl_i.addr] <= 8'hff;
		if (ctrl_i.prog)
			cells[ctrl_i.addr] <= ctrl_i.wdata;
		if (ctrl_i.read)
			last <= cells[ctrl_i.addr];
	end

	// Undriven read lines show the inverse of the last byte read
	always_comb begin
		rdata_o = ctrl_i.read ? cells[ctrl_i.addr] : ~last;
	end
endmodule // flash_array_model

`default_nettype wire

// >>> dv/in_system_flash_programmer_sva.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Port checks of the sequencer
module in_system_flash_programmer_sva
	import flash_prog_pkg::*;
(
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic        wb_ack_o,
	input  wire logic        wb_err_o,
	input  wire logic        cpu_hold_o,
	input  wire flash_ctrl_t flash_ctrl_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic strobe;
	logic trig;

	// Any array strobe, and a go write on the bus
	assign strobe = flash_ctrl_o.erase | flash_ctrl_o.prog | flash_ctrl_o.read;
	assign trig   = wb_cyc_i & wb_stb_i & wb_we_i & wb_adr_i == FLASH_TRIG_OFS & wb_dat_i[0];

	chk_answer_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o
		|=> wb_ack_o || wb_err_o) else $error("No bus answer");
	chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("Ack too long");
	chk_ack_mapped: assert property (wb_ack_o |-> $past(wb_adr_i) <= STATUS_OFS)
		else $error("Ack on unmapped address");
	chk_hold_from_go: assert property ($rose(cpu_hold_o) |-> $past(trig) || $past(trig, 2))
		else $error("Hold without go write");
	chk_setup_pump: assert property ($rose(cpu_hold_o) |->
		!flash_ctrl_o.pump_on [*5] ##1 flash_ctrl_o.pump_on) else $error("Pump timing wrong");
	chk_strobe_held: assert property (strobe |-> cpu_hold_o) else $error("Strobe unheld");
	chk_release_after: assert property ($fell(cpu_hold_o) |-> $past(strobe))
		else $error("Early release");
	chk_one_strobe: assert property ($onehot0({flash_ctrl_o.erase, flash_ctrl_o.prog,
		flash_ctrl_o.read})) else $error("Two strobes");
	chk_addr_frozen: assert property (cpu_hold_o && $past(cpu_hold_o)
		|-> $stable(flash_ctrl_o.addr)) else $error("Address moved");
endmodule // in_system_flash_programmer_sva

bind in_system_flash_programmer in_system_flash_programmer_sva chk (.clk_i(clk_i),
	.rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i),
	.wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_ack_o(wb_ack_o), .wb_err_o(wb_err_o),
	.cpu_hold_o(cpu_hold_o), .flash_ctrl_o(flash_ctrl_o));

`default_nettype wire

// >>> dv/in_system_flash_programmer_tb_top.sv
`timescale 1ns/10ps
`default_nettype none

// ==========================================
// Register level bench
module in_system_flash_programmer_tb_top;
	import flash_prog_pkg::*;
	logic        clk_i, rst_i, req, we, ack, err, hold, er;
	logic [7:0]  adr, rdata;
	logic [31:0] wdat, dat_o, rd;
	flash_ctrl_t ctrl;
	int          n_mismatch, checks;
	logic [7:0]  cmds [3] = '{CMD_ERASE, CMD_PROGRAM, CMD_VERIFY};
	logic [7:0]  cell_exp [3] = '{8'hff, 8'h5a, 8'h5a};

	always #20 clk_i = ~clk_i;

	in_system_flash_programmer #(.ERASE_CYCLES(20)) dut (.clk_i(clk_i), .rst_i(rst_i),
		.wb_cyc_i(req), .wb_stb_i(req), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hf),
		.wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack), .wb_err_o(err),
		.cpu_hold_o(hold), .flash_ctrl_o(ctrl), .flash_rdata_i(rdata));
	flash_array_model flash (.clk_i(clk_i), .ctrl_i(ctrl), .rdata_o(rdata));

	task automatic summarize;
		if (n_mismatch == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask

	// One classic cycle, then one idle cycle
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		req  <= 1'b1;
		we   <= w;
		adr  <= a;
		wdat <= d;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (ack !== 1'b1 && err !== 1'b1 && n < 40);
		rd = dat_o;
		er = err;
		if (n == 40)
			chk(32'h0, 32'h1);
		if (n == 40)
			summarize();
		req <= 1'b0;
		@(posedge clk_i);
	endtask

	task automatic unlock;
		bus(1'b1, UNLOCK_OFS, {24'h0, UNLOCK_KEY1});
		bus(1'b1, UNLOCK_OFS, {24'h0, UNLOCK_KEY2});
	endtask

	// Trigger and wait for completion
	task automatic run;
		int n;
		unlock();
		bus(1'b1, FLASH_TRIG_OFS, 32'h1);
		chk(hold, 1'b1);
		bus(1'b0, FLASH_TRIG_OFS, 32'h0);
		chk(rd, 32'h1);
		bus(1'b1, FLASH_ADDR_LO_OFS, 32'h77);
		n = 0;
		while (hold === 1'b1 && n < 2000) begin
			@(posedge clk_i);
			n++;
		end
		chk(n < 2000, 1'b1);
		bus(1'b0, FLASH_TRIG_OFS, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, STATUS_OFS, 32'h0);
		chk(rd, 32'h0);
		bus(1'b0, FLASH_ADDR_LO_OFS, 32'h0);
		chk(rd, 32'h34);
	endtask

	// Main sequence
	initial begin
		clk_i = 1'b0;
		rst_i = 1'b1;
		req = 1'b0;
		we = 1'b0;
		adr = 8'h00;
		wdat = 32'h0;
		n_mismatch = 0;
		checks = 0;
		repeat (12) @(posedge clk_i);
		rst_i <= 1'b0;
		@(posedge clk_i);
		bus(1'b0, CHIP_CONTROL_OFS, 32'h0);
		chk(rd, 32'h0);
		unlock();
		bus(1'b1, FLASH_TRIG_OFS, 32'h1);
		chk(hold, 1'b0);
		bus(1'b0, STATUS_OFS, 32'h0);
		chk(rd, 32'h2);
		unlock();
		bus(1'b1, CHIP_CONTROL_OFS, 32'h1);
		bus(1'b0, CHIP_CONTROL_OFS, 32'h0);
		chk(rd, 32'h1);
		bus(1'b1, FLASH_ADDR_HI_OFS, 32'h12);
		bus(1'b1, FLASH_ADDR_LO_OFS, 32'h34);
		bus(1'b1, FLASH_DATA_OFS, 32'h5a);
		bus(1'b1, FLASH_TRIG_OFS, 32'h1);
		chk(hold, 1'b0);
		unlock();
		bus(1'b1, FLASH_DATA_OFS, 32'h5a);
		bus(1'b1, FLASH_TRIG_OFS, 32'h1);
		chk(hold, 1'b0);
		foreach (cmds[i]) begin
			bus(1'b1, FLASH_CMD_OFS, {24'h0, cmds[i]});
			run();
			chk(flash.cells[16'h1234], cell_exp[i]);
		end
		bus(1'b1, FLASH_DATA_OFS, 32'ha5);
		bus(1'b0, FLASH_DATA_OFS, 32'h0);
		chk(rd, 32'h5a);
		chk(flash.cells[16'h1234], 8'h5a);
		bus(1'b0, 8'h20, 32'h0);
		chk(er, 1'b1);
		summarize();
	end
endmodule // in_system_flash_programmer_tb_top

`default_nettype wire
